// ==== rtl/ops_top.sv ====
// display driver core: hardware reset state, display state and register port
//
// Operation
// - reset input low clears state, display off
// - reset selects 480x128 mode, normal mapping
// - reset sets start line to zero
// - reset clears column address counter
// - reset selects normal common scan direction
// - reset loads contrast with 7fh
`timescale 1ns/1ps
`default_nettype none
module ops_top #(
  parameter int COLS  = 480,
  parameter int ROWS  = 128,
  parameter int COL_W = $clog2(COLS),
  parameter int ROW_W = $clog2(ROWS)
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST,
  // pins from the host
  input  wire logic             INIT_IN_N,
  input  wire logic             LOGIC_SUPPLY,
  input  wire logic             IO_SUPPLY,
  // register port
  input  wire logic [3:0]       ADDR,
  input  wire logic [7:0]       WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [7:0]       RDATA,
  // display state
  output logic                  DISP_ON,
  output logic                  MODE_480,
  output logic                  SEG_REMAP,
  output logic                  SCAN_REV,
  output logic      [ROW_W-1:0] START_LINE,
  output logic      [COL_W-1:0] COLUMN,
  output logic      [7:0]       CONTRAST,
  output logic                  IN_RESET
);

  localparam logic [COL_W-1:0] COL_LAST = COL_W'(COLS - 1);
  localparam logic [COL_W-1:0] COL_ZERO = '0;
  localparam logic [ROW_W-1:0] ROW_ZERO = '0;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  ops_pin_if pins ();

  ops_pin_sync u_sync (
    .CLK          (CLK),
    .RST          (RST),
    .init_in_n    (INIT_IN_N),
    .logic_supply (LOGIC_SUPPLY),
    .io_supply    (IO_SUPPLY),
    .pins         (pins)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // internal reset: the synchronised reset pin acts like the system reset on all display state; RDATA is cleared by RST only
  logic hold;
  logic wr_ok;
  assign hold  = RST || !pins.init_ok;
  assign wr_ok = WR && !hold;

  // ----------------------------------------------------------------
  // display state
  // ----------------------------------------------------------------
  ops_pkg::ops_state_t state;
  ops_pkg::ops_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ops_pkg::ST_HOLD: begin
        next_state = ops_pkg::ST_OFF;
      end
      ops_pkg::ST_OFF: begin
        if (wr_ok && hit(ADDR, ops_pkg::ADDR_CTRL) && WDATA[ops_pkg::CTRL_ON_BIT]) begin
          next_state = ops_pkg::ST_ON;
        end
      end
      ops_pkg::ST_ON: begin
        if (wr_ok && hit(ADDR, ops_pkg::ADDR_CTRL) && !WDATA[ops_pkg::CTRL_ON_BIT]) begin
          next_state = ops_pkg::ST_OFF;
        end
      end
      default: begin
        next_state = ops_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (hold) begin
      state <= ops_pkg::ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // display output is off whenever the state is not on, so also in reset
  assign DISP_ON  = (state == ops_pkg::ST_ON);
  assign IN_RESET = (state == ops_pkg::ST_HOLD);

  // ----------------------------------------------------------------
  // mapping and scan direction
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (hold) begin
      SEG_REMAP <= ops_pkg::RST_SEGREMAP;
      SCAN_REV  <= ops_pkg::RST_SCANREV;
    end else if (wr_ok && hit(ADDR, ops_pkg::ADDR_CTRL)) begin
      SEG_REMAP <= WDATA[ops_pkg::CTRL_SEGREMAP_BIT];
      SCAN_REV  <= WDATA[ops_pkg::CTRL_SCANREV_BIT];
    end
  end

  // only one display mode is offered; it is fixed by reset
  always_ff @(posedge CLK) begin
    if (hold) begin
      MODE_480 <= ops_pkg::RST_MODE_480;
    end
  end

  // ----------------------------------------------------------------
  // start line
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (hold) begin
      START_LINE <= ROW_ZERO;
    end else if (wr_ok && hit(ADDR, ops_pkg::ADDR_START)) begin
      START_LINE <= WDATA[ROW_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // column address counter: loaded directly, stepped by each data write
  // an out-of-range load is ignored rather than clipped, so software
  // sees the old column on read back and can detect the slip
  // ----------------------------------------------------------------
  logic [COL_W-1:0] col_load;
  assign col_load = COL_W'(WDATA);

  always_ff @(posedge CLK) begin
    if (hold) begin
      COLUMN <= COL_ZERO;
    end else if (wr_ok && hit(ADDR, ops_pkg::ADDR_COLUMN)) begin
      if (col_load <= COL_LAST) begin
        COLUMN <= col_load;
      end
    end else if (wr_ok && hit(ADDR, ops_pkg::ADDR_DATA)) begin
      if (COLUMN == COL_LAST) begin
        COLUMN <= COL_ZERO;
      end else begin
        COLUMN <= COLUMN + COL_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // contrast
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (hold) begin
      CONTRAST <= ops_pkg::RST_CONTRAST;
    end else if (wr_ok && hit(ADDR, ops_pkg::ADDR_CONTRAST)) begin
      CONTRAST <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // read back; status stays readable while the reset pin holds the device in reset, but RDATA reads zero during RST
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (hit(ADDR, ops_pkg::ADDR_CTRL)) begin
      next_rdata[ops_pkg::CTRL_ON_BIT]       = DISP_ON;
      next_rdata[ops_pkg::CTRL_SCANREV_BIT]  = SCAN_REV;
      next_rdata[ops_pkg::CTRL_SEGREMAP_BIT] = SEG_REMAP;
    end else if (hit(ADDR, ops_pkg::ADDR_START)) begin
      next_rdata = 8'(START_LINE);
    end else if (hit(ADDR, ops_pkg::ADDR_COLUMN)) begin
      next_rdata = COLUMN[7:0];
    end else if (hit(ADDR, ops_pkg::ADDR_CONTRAST)) begin
      next_rdata = CONTRAST;
    end else if (hit(ADDR, ops_pkg::ADDR_STATUS)) begin
      next_rdata[ops_pkg::STAT_RESET_BIT] = IN_RESET;
      next_rdata[ops_pkg::STAT_LOGIC_BIT] = pins.logic_ok;
      next_rdata[ops_pkg::STAT_IO_BIT]    = pins.io_ok;
      next_rdata[ops_pkg::STAT_ON_BIT]    = DISP_ON;
      next_rdata[ops_pkg::STAT_MODE_BIT]  = MODE_480;
    end
  end

  // read data stand for the one cycle after the strobe and read zero otherwise
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= ops_pkg::RST_RDATA;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= ops_pkg::RST_RDATA;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/ops_pkg.sv ====
// constants and types shared by the display power and reset core
package ops_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_START    = 4'h1;
  localparam logic [3:0] ADDR_COLUMN   = 4'h2;
  localparam logic [3:0] ADDR_CONTRAST = 4'h3;
  localparam logic [3:0] ADDR_DATA     = 4'h4;
  localparam logic [3:0] ADDR_STATUS   = 4'h5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT      = 0;
  localparam int CTRL_SCANREV_BIT = 1;
  localparam int CTRL_SEGREMAP_BIT = 2;
  localparam int STAT_RESET_BIT   = 0;
  localparam int STAT_LOGIC_BIT   = 1;
  localparam int STAT_IO_BIT      = 2;
  localparam int STAT_ON_BIT      = 3;
  localparam int STAT_MODE_BIT    = 4;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTRAST = 8'h7f;
  localparam logic       RST_SCANREV  = 1'h0;
  localparam logic       RST_SEGREMAP = 1'h0;
  localparam logic       RST_MODE_480 = 1'h1;
  localparam logic [7:0] RST_RDATA    = 8'h00;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
  localparam int PIN_COUNT   = 3;

  // ----------------------------------------------------------------
  // display state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_OFF  = 3'b010,
    ST_ON   = 3'b100
  } ops_state_t;

endpackage

// ==== rtl/ops_pin_if.sv ====
// synchronised pin levels passed from the pin synchroniser to the core
`timescale 1ns/1ps
`default_nettype none
interface ops_pin_if;
  logic init_ok;
  logic logic_ok;
  logic io_ok;
  modport sync (output init_ok, output logic_ok, output io_ok);
  modport core (input init_ok, input logic_ok, input io_ok);
endinterface
`default_nettype wire

// ==== rtl/ops_pin_sync.sv ====
// two-stage synchroniser for the reset and supply-good pins
`timescale 1ns/1ps
`default_nettype none
module ops_pin_sync (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // raw pins
  input  wire logic init_in_n,
  input  wire logic logic_supply,
  input  wire logic io_supply,
  // synchronised levels
  ops_pin_if.sync   pins
);

  logic [ops_pkg::PIN_COUNT-1:0] raw;
  logic [ops_pkg::PIN_COUNT-1:0] meta;
  logic [ops_pkg::PIN_COUNT-1:0] stable;

  assign raw = {io_supply, logic_supply, init_in_n};

  // ----------------------------------------------------------------
  // one pair of flops per pin; resetting to 0 keeps the core in reset
  // until the pin has really been seen high
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ops_pkg::PIN_COUNT; g++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (RST) begin
          meta[g]   <= 1'b0;
          stable[g] <= 1'b0;
        end else begin
          meta[g]   <= raw[g];
          stable[g] <= meta[g];
        end
      end
    end
  endgenerate

  assign pins.init_ok  = stable[0];
  assign pins.logic_ok = stable[1];
  assign pins.io_ok    = stable[2];

endmodule
`default_nettype wire

// ==== rtl/ops_end.sv ====
// intentionally minimal: no further design content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bench/ops_top_props.sv ====
// reset-state assertions on the display core ports
`timescale 1ns/1ps
`default_nettype none
module ops_top_props #(
  parameter int COLS  = 480,
  parameter int ROWS  = 128,
  parameter int COL_W = 9,
  parameter int ROW_W = 7
) (
  // clock and reset
  input wire logic             CLK,
  input wire logic             RST,
  // pin and display state
  input wire logic             INIT_IN_N,
  input wire logic             DISP_ON,
  input wire logic             MODE_480,
  input wire logic             SEG_REMAP,
  input wire logic             SCAN_REV,
  input wire logic [ROW_W-1:0] START_LINE,
  input wire logic [COL_W-1:0] COLUMN,
  input wire logic [7:0]       CONTRAST,
  input wire logic             IN_RESET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // hold sequences
  // ----------------------------------------------------------------
  // two samples of hold, so the entry edge itself is not judged
  sequence s_held;
    IN_RESET [*2];
  endsequence
  // pin low long enough to pass both sync flops and the state flop
  sequence s_pin_low;
    !INIT_IN_N [*4];
  endsequence
  AST_PIN_HOLD: assert property (s_pin_low |-> IN_RESET)
    else $error("pin held low without hold state");
  // pin edge passes two sync flops and the state flop before the display drops
  AST_OFF_HELD: assert property ($fell(INIT_IN_N) |-> ##3 !DISP_ON)
    else $error("display still on after reset pin fell");
  AST_MODE: assert property (s_held |-> MODE_480 && !SEG_REMAP)
    else $error("mode or mapping wrong during hold");
  AST_START: assert property (s_held |-> ~|START_LINE)
    else $error("start line not zero during hold");
  AST_COLUMN: assert property (s_held |-> ~|COLUMN)
    else $error("column counter not zero during hold");
  AST_SCAN: assert property (s_held |-> !SCAN_REV)
    else $error("scan reversed during hold");
  AST_CONTRAST: assert property (s_held |-> CONTRAST == 8'h7f)
    else $error("contrast not default during hold");
  AST_EXIT: assert property ($fell(IN_RESET) |-> !DISP_ON && CONTRAST == 8'h7f)
    else $error("state lost on leaving hold");
endmodule
bind ops_top ops_top_props #(.COLS(COLS), .ROWS(ROWS), .COL_W(COL_W), .ROW_W(ROW_W)) i_props (
  .CLK(CLK), .RST(RST), .INIT_IN_N(INIT_IN_N), .DISP_ON(DISP_ON), .MODE_480(MODE_480),
  .SEG_REMAP(SEG_REMAP), .SCAN_REV(SCAN_REV), .START_LINE(START_LINE), .COLUMN(COLUMN),
  .CONTRAST(CONTRAST), .IN_RESET(IN_RESET));
`default_nettype wire

// ==== bench/ops_host_model.sv ====
// host model: supplies, panel supply and the reset pin
`timescale 1ns/1ps
`default_nettype none
module ops_host_model #(
  parameter int SETTLE = 50,
  parameter int DRAIN  = 25
) (
  input  wire logic clk,
  output logic      supply_ok,
  output logic      init_n,
  output logic      panel,
  output logic      may_show
);
  // waits are scaled down; only their order is modelled
  initial begin
    supply_ok = 1'b0;
    init_n = 1'b0;
    panel = 1'b0;
    may_show = 1'b0;
  end
  task automatic power_up();
    supply_ok <= 1'b1;
    repeat (4) @(posedge clk);
    init_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic panel_on();
    if (init_n && supply_ok) begin
      panel <= 1'b1;
      repeat (SETTLE) @(posedge clk);
      may_show <= 1'b1;
      // let the flag settle before the caller reads it for the display-on write
      @(posedge clk);
    end
  endtask
  task automatic power_down();
    may_show <= 1'b0;
    panel <= 1'b0;
    repeat (DRAIN) @(posedge clk);
    supply_ok <= 1'b0;
    @(posedge clk);
  endtask
  task automatic noise_reset(input int n);
    panel <= 1'b0;
    may_show <= 1'b0;
    init_n <= 1'b0;
    repeat (n) @(posedge clk);
    init_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/ops_top_tb.sv ====
// self-checking bench for the display core
`timescale 1ns/1ps
`default_nettype none
module ops_top_tb;
  logic       clk, rst, wr, rd, rd_q, sup, init_n, show;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, exp_v, v;
  logic [7:0] exp_q[$];
  int         seed = 47305;
  int         errors = 0;
  int         num_checks = 0;
  int         cycles = 0;
  ops_top i_dut (.CLK(clk), .RST(rst), .INIT_IN_N(init_n), .LOGIC_SUPPLY(sup),
    .IO_SUPPLY(sup), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .DISP_ON(), .MODE_480(), .SEG_REMAP(), .SCAN_REV(), .START_LINE(), .COLUMN(),
    .CONTRAST(), .IN_RESET());
  ops_host_model i_host (.clk(clk), .supply_ok(sup), .init_n(init_n), .panel(),
    .may_show(show));
  always #2 clk = ~clk;
  // read data stand one cycle after the strobe, so compare one edge later
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) begin
      exp_v = exp_q.pop_front();
      num_checks++;
      if (rdata !== exp_v) begin
        errors++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, rdata, exp_v);
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      final_report();
    end
  end
  // every step assigns each bus signal once, so strobes may follow back to back
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rdx(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'($random(seed)));
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task automatic defaults(input logic [7:0] stat);
    rdx(ops_pkg::ADDR_CTRL, 8'h00);
    rdx(ops_pkg::ADDR_START, 8'h00);
    rdx(ops_pkg::ADDR_COLUMN, 8'h00);
    rdx(ops_pkg::ADDR_CONTRAST, 8'h7f);
    rdx(ops_pkg::ADDR_STATUS, stat);
    idle(2);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    rd_q = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    i_host.power_up();
    idle(4);
    defaults(8'h16);
    $display("test defaults done");
    // display off, then clear by stepping the column past the last one
    bus(1'b1, 1'b0, ops_pkg::ADDR_CTRL, 8'h00);
    bus(1'b1, 1'b0, ops_pkg::ADDR_COLUMN, 8'hff);
    repeat (225) bus(1'b1, 1'b0, ops_pkg::ADDR_DATA, 8'($random(seed)));
    rdx(ops_pkg::ADDR_COLUMN, 8'h00);
    rdx(4'hf, 8'h00);
    idle(1);
    i_host.panel_on();
    v = 8'($random(seed));
    bus(1'b1, 1'b0, ops_pkg::ADDR_CTRL, {5'h00, 2'h3, show});
    bus(1'b1, 1'b0, ops_pkg::ADDR_CONTRAST, v);
    bus(1'b1, 1'b0, ops_pkg::ADDR_START, v);
    bus(1'b1, 1'b0, ops_pkg::ADDR_COLUMN, v);
    rdx(ops_pkg::ADDR_CTRL, 8'h07);
    rdx(ops_pkg::ADDR_COLUMN, v);
    rdx(ops_pkg::ADDR_START, v & 8'h7f);
    rdx(ops_pkg::ADDR_CONTRAST, v);
    rdx(ops_pkg::ADDR_STATUS, 8'h1e);
    idle(1);
    $display("test writes done");
    fork
      i_host.noise_reset(8);
      begin
        idle(5);
        bus(1'b1, 1'b0, ops_pkg::ADDR_CONTRAST, 8'h55);
        rdx(ops_pkg::ADDR_STATUS, 8'h17);
        idle(1);
      end
    join
    idle(4);
    defaults(8'h16);
    $display("test noise reset done");
    bus(1'b1, 1'b0, ops_pkg::ADDR_CTRL, 8'h00);
    idle(1);
    i_host.power_down();
    idle(3);
    rdx(ops_pkg::ADDR_STATUS, 8'h10);
    idle(2);
    $display("test power down done");
    final_report();
  end
endmodule
`default_nettype wire
